// >>> src/lscp_core.sv
// Switch configuration path: upstream record splitter and switch reset latch
`default_nettype none
module lscp_core (
  input  wire logic        clock,
  input  wire logic        sys_rst,
  // Upstream configuration link, byte stream
  input  wire logic        up_valid,
  input  wire logic [7:0]  up_data,
  output logic             up_ready,
  // Switch configuration link, byte stream
  output logic             sw_valid,
  output logic [7:0]       sw_data,
  input  wire logic        sw_ready,
  // Downstream configuration link, byte stream
  output logic             dn_valid,
  output logic [7:0]       dn_data,
  input  wire logic        dn_ready,
  // External memory interface of the processor
  input  wire logic        ext_wr,
  input  wire logic        ext_rd,
  input  wire logic [15:0] ext_wdata,
  // Switch hard reset pin, active high
  output logic             sw_rst
);

  lscp_pkg::lscp_regs_t cur_q;
  lscp_pkg::lscp_regs_t nxt_d;

  ////////////////////////////////////////////////////////////////////////////
  // Record decoding helpers

  // Upstream records are four bytes: hop, opcode, port a, port b.
  // Hop zero means the record is for this board's own switch.
  // Local connect leaves on the switch link as opcode, port a, port b.
  // Local soft reset leaves on the switch link as the opcode byte alone.
  // Other records leave whole on the downstream link with one hop less,
  // so one head link can set up every switch along a chain of boards.
  // Local records with an unknown opcode, or connects with an out-of-range port, are dropped:
  // passing them on would let a bad record confuse a later board.
  // Limitation: a record is never split, so upstream waits while one drains.

  // Hop count run out: the record belongs to this board
  function automatic logic is_local(input lscp_pkg::lscp_regs_t r);
    is_local = (r.hop == lscp_pkg::HOP_LOCAL);
  endfunction

  // Byte counter step, shared by collecting and sending
  function automatic logic [2:0] idx_next(input logic [2:0] i);
    idx_next = i + 3'h1;
  endfunction

  // A byte on either outgoing link was accepted at this edge
  function automatic logic byte_taken(input lscp_pkg::lscp_regs_t r,
                                      input logic                 sw_rdy,
                                      input logic                 dn_rdy);
    byte_taken = (r.sw_valid && sw_rdy) || (r.dn_valid && dn_rdy);
  endfunction

  // A port number must name one of the switch's ports
  function automatic logic port_ok(input logic [7:0] p);
    port_ok = (p < lscp_pkg::NUM_PORTS);
  endfunction

  // Bytes to emit for the held record; zero drops a malformed local record
  function automatic logic [2:0] msg_len(input lscp_pkg::lscp_regs_t r);
    logic [2:0] n;
    n = lscp_pkg::LEN_NONE;
    if (!is_local(r)) begin
      n = lscp_pkg::LEN_FWD;
    end else if (r.op == lscp_pkg::OP_SOFTRST) begin
      n = lscp_pkg::LEN_SOFT;
    end else if (r.op == lscp_pkg::OP_CONNECT && port_ok(r.pa) && port_ok(r.pb)) begin
      n = lscp_pkg::LEN_CONN;
    end
    msg_len = n;
  endfunction

  // Byte i of the emitted message; forwarded records carry one hop less
  function automatic logic [7:0] msg_byte(input lscp_pkg::lscp_regs_t r,
                                          input logic [2:0]          i);
    logic [7:0] b;
    b = lscp_pkg::BYTE_ZERO;
    if (!is_local(r)) begin
      unique case (i)
        lscp_pkg::IDX_HOP: b = r.hop - lscp_pkg::HOP_STEP;
        lscp_pkg::IDX_OP:  b = r.op;
        lscp_pkg::IDX_PA:  b = r.pa;
        default:           b = r.pb;
      endcase
    end else begin
      unique case (i)
        lscp_pkg::IDX_HOP: b = r.op;
        lscp_pkg::IDX_OP:  b = r.pa;
        default:           b = r.pb;
      endcase
    end
    msg_byte = b;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  // Everything is decided from the registered copy of the state
  always_comb begin
    logic       is_loc;
    logic       taken;
    logic [2:0] len;
    is_loc = 1'b0;
    taken  = 1'b0;
    len    = lscp_pkg::LEN_NONE;
    nxt_d  = cur_q;

    // Reset latch follows writes only; reads leave it alone rather than undefined,
    // so a stray read can never pulse the switch into reset
    if (ext_wr) begin
      nxt_d.sw_rst = ext_wdata[lscp_pkg::RST_BIT];
    end else if (ext_rd) begin
      nxt_d.sw_rst = cur_q.sw_rst;
    end

    unique case (cur_q.st)
      lscp_pkg::LSCP_COLLECT: begin
        // Gather one whole record before deciding where it goes
        if (up_valid && cur_q.up_ready) begin
          unique case (cur_q.idx)
            lscp_pkg::IDX_HOP: nxt_d.hop = up_data;
            lscp_pkg::IDX_OP:  nxt_d.op  = up_data;
            lscp_pkg::IDX_PA:  nxt_d.pa  = up_data;
            default:           nxt_d.pb  = up_data;
          endcase
          if (cur_q.idx == lscp_pkg::IDX_LAST) begin
            nxt_d.idx      = lscp_pkg::IDX_HOP;
            nxt_d.up_ready = 1'b0; // Stall upstream while the record is sent
            nxt_d.st       = lscp_pkg::LSCP_SEND;
          end else begin
            nxt_d.idx = idx_next(cur_q.idx);
          end
        end
      end
      lscp_pkg::LSCP_SEND: begin
        is_loc = is_local(cur_q);
        len    = msg_len(cur_q);
        taken  = byte_taken(cur_q, sw_ready, dn_ready);
        // Only one link holds a byte at a time, so one data register serves both
        if (!(cur_q.sw_valid || cur_q.dn_valid) || taken) begin
          if (cur_q.idx < len) begin
            // Offer the next byte on the link the record is bound for
            nxt_d.out_data = msg_byte(cur_q, cur_q.idx);
            nxt_d.sw_valid = is_loc;
            nxt_d.dn_valid = !is_loc;
            nxt_d.idx      = idx_next(cur_q.idx);
          end else begin
            // Message done, or dropped: reopen the upstream link
            nxt_d.sw_valid = 1'b0;
            nxt_d.dn_valid = 1'b0;
            nxt_d.idx      = lscp_pkg::IDX_HOP;
            nxt_d.up_ready = 1'b1;
            nxt_d.st       = lscp_pkg::LSCP_COLLECT;
          end
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  // Register contents after processor reset; all constants
  function automatic lscp_pkg::lscp_regs_t idle_regs();
    lscp_pkg::lscp_regs_t s;
    s.st       = lscp_pkg::LSCP_COLLECT;
    s.idx      = lscp_pkg::IDX_HOP;
    s.hop      = lscp_pkg::BYTE_ZERO;
    s.op       = lscp_pkg::BYTE_ZERO;
    s.pa       = lscp_pkg::BYTE_ZERO;
    s.pb       = lscp_pkg::BYTE_ZERO;
    s.up_ready = 1'b1;
    s.sw_valid = 1'b0;
    s.dn_valid = 1'b0;
    s.out_data = lscp_pkg::BYTE_ZERO;
    s.sw_rst   = lscp_pkg::RST_ON;
    idle_regs  = s;
  endfunction

  // Processor reset holds the switch in hard reset until software releases it;
  // afterwards only external writes move the latch, so it runs on its own
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cur_q <= idle_regs();
    end else begin
      cur_q <= nxt_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs straight from the state register

  // Handshake flags
  assign up_ready = cur_q.up_ready;
  assign sw_valid = cur_q.sw_valid;
  assign dn_valid = cur_q.dn_valid;

  // One data register feeds both links; the valid flags say whose byte it is
  assign sw_data  = cur_q.out_data;
  assign dn_data  = cur_q.out_data;

  // Switch hard reset pin from the latch
  assign sw_rst   = cur_q.sw_rst;

endmodule
`default_nettype wire

// >>> shared/lscp_pkg.sv
// Package of constants for the switch configuration path
`default_nettype none
package lscp_pkg;
  // Record layout on the upstream link: hop, opcode, port a, port b
  localparam int unsigned REC_BYTES  = 4;
  localparam int unsigned IDX_W      = 3;
  localparam logic [2:0]  IDX_HOP    = 3'h0;
  localparam logic [2:0]  IDX_OP     = 3'h1;
  localparam logic [2:0]  IDX_PA     = 3'h2;
  localparam logic [2:0]  IDX_PB     = 3'h3;
  localparam logic [2:0]  IDX_LAST   = 3'h3;
  // Lengths of the emitted messages in bytes
  localparam logic [2:0]  LEN_NONE   = 3'h0;
  localparam logic [2:0]  LEN_SOFT   = 3'h1;
  localparam logic [2:0]  LEN_CONN   = 3'h3;
  localparam logic [2:0]  LEN_FWD    = 3'h4;
  // Switch has 32 link ports
  localparam logic [7:0]  NUM_PORTS  = 8'h20;
  // Command codes carried in the opcode byte
  localparam logic [7:0]  OP_CONNECT = 8'h00;
  localparam logic [7:0]  OP_SOFTRST = 8'h01;
  localparam logic [7:0]  HOP_LOCAL  = 8'h00;
  localparam logic [7:0]  HOP_STEP   = 8'h01;
  // Bit of external write data that sets the switch reset level
  localparam int unsigned RST_BIT    = 0;
  localparam logic        RST_ON     = 1'b1;
  localparam logic [7:0]  BYTE_ZERO  = 8'h00;

  typedef enum logic [1:0] {
    LSCP_COLLECT = 2'b01,
    LSCP_SEND    = 2'b10
  } lscp_state_t;

  typedef struct packed {
    lscp_state_t      st;
    logic [2:0]       idx;
    logic [7:0]       hop;
    logic [7:0]       op;
    logic [7:0]       pa;
    logic [7:0]       pb;
    logic             up_ready;
    logic             sw_valid;
    logic             dn_valid;
    logic [7:0]       out_data;
    logic             sw_rst;
  } lscp_regs_t;
endpackage
`default_nettype wire

// >>> test/lscp_core_assertions.sv
// Port checker of the switch configuration path
`default_nettype none
module lscp_core_chk (
  input wire logic        clock,
  input wire logic        sys_rst,
  input wire logic        up_valid,
  input wire logic [7:0]  up_data,
  input wire logic        up_ready,
  input wire logic        sw_valid,
  input wire logic [7:0]  sw_data,
  input wire logic        sw_ready,
  input wire logic        dn_valid,
  input wire logic [7:0]  dn_data,
  input wire logic        dn_ready,
  input wire logic        ext_wr,
  input wire logic        ext_rd,
  input wire logic [15:0] ext_wdata,
  input wire logic        sw_rst
);
  timeunit 1ns;
  timeprecision 1ps;
  // One domain, so clock and reset are given once
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////////////////////
  AST_RST_SET: assert property (ext_wr && ext_wdata[0] |=> sw_rst)
    else $error("reset pin not set");
  AST_RST_CLR: assert property (ext_wr && !ext_wdata[0] |=> !sw_rst)
    else $error("reset pin not released");
  AST_RST_HOLD: assert property (!ext_wr |=> $stable(sw_rst))
    else $error("reset pin moved without write");
  AST_RD_KEEP: assert property (ext_rd && !ext_wr |=> $stable(sw_rst))
    else $error("reset pin moved on read");
  AST_SW_HOLD: assert property (
    sw_valid && !sw_ready |=> sw_valid && $stable(sw_data))
    else $error("switch byte dropped");
  AST_DN_HOLD: assert property (
    dn_valid && !dn_ready |=> dn_valid && $stable(dn_data))
    else $error("downstream byte dropped");
  AST_ONE_LINK: assert property (!(sw_valid && dn_valid))
    else $error("both links offered");
  AST_NO_TAKE: assert property (sw_valid || dn_valid |-> !up_ready)
    else $error("upstream open while sending");
  AST_SEND_SOON: assert property (
    $fell(up_ready) |-> ##[1:3] (sw_valid || dn_valid || up_ready))
    else $error("record not emitted in time");
endmodule
`default_nettype wire

// >>> test/lscp_sink.sv
// Far-side receiver model, prompt or stalling at random
`default_nettype none
module lscp_sink (
  input  wire logic clock,
  input  wire logic slow,
  output logic      ready
);
  timeunit 1ns;
  timeprecision 1ps;
  initial ready = 1'b0;
  // Next board or switch takes bytes; random stalls stress the hold logic
  always @(posedge clock) begin
    ready <= #1 slow ? 1'($urandom_range(0, 1)) : 1'b1;
  end
endmodule
`default_nettype wire

// >>> test/link_switch_config_path_tb.sv
// Self-checking bench of the switch configuration path
`default_nettype none
module link_switch_config_path_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0, sys_rst = 1'b1, up_valid = 1'b0, ext_wr = 1'b0, ext_rd = 1'b0;
  logic slow = 1'b0, up_ready, sw_valid, sw_ready, dn_valid, dn_ready, sw_rst;
  logic [7:0]  up_data = 8'h00, sw_data, dn_data;
  logic [15:0] ext_wdata = 16'h0000;
  logic [8:0]  exp_q[$];
  int          n_fail = 0, total_checks = 0;
  always #4 clock = ~clock;
  lscp_core uut (
    .clock     (clock),
    .sys_rst   (sys_rst),
    .up_valid  (up_valid),
    .up_data   (up_data),
    .up_ready  (up_ready),
    .sw_valid  (sw_valid),
    .sw_data   (sw_data),
    .sw_ready  (sw_ready),
    .dn_valid  (dn_valid),
    .dn_data   (dn_data),
    .dn_ready  (dn_ready),
    .ext_wr    (ext_wr),
    .ext_rd    (ext_rd),
    .ext_wdata (ext_wdata),
    .sw_rst    (sw_rst)
  );
  lscp_sink sw_side (.clock(clock), .slow(slow), .ready(sw_ready));
  lscp_sink dn_side (.clock(clock), .slow(slow), .ready(dn_ready));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [8:0] got, input logic [8:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    if (n_fail == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Watcher: each byte taken must match the oldest note
  always @(posedge clock) begin
    if (sw_valid === 1'b1 && sw_ready === 1'b1) begin
      check({1'b0, sw_data}, exp_q.size() ? exp_q.pop_front() : 9'h1FF);
    end
    if (dn_valid === 1'b1 && dn_ready === 1'b1) begin
      check({1'b1, dn_data}, exp_q.size() ? exp_q.pop_front() : 9'h1FF);
    end
  end
  // Upstream byte, held until the core takes it
  task automatic put(input logic [7:0] b);
    int k;
    k = 0;
    up_valid = 1'b1;
    up_data = b;
    while (up_ready !== 1'b1 && k < 500) begin
      @(posedge clock);
      #1 k++;
    end
    if (k >= 500) begin
      n_fail++;
      close_out();
    end else begin
      @(posedge clock);
      #1;
    end
  endtask
  // Record: notes what must leave, then sends four bytes
  task automatic rec(input logic [7:0] h, input logic [7:0] o, input logic [7:0] a,
                     input logic [7:0] b);
    if (h !== lscp_pkg::HOP_LOCAL) begin
      exp_q.push_back({1'b1, h - lscp_pkg::HOP_STEP});
      exp_q.push_back({1'b1, o});
      exp_q.push_back({1'b1, a});
      exp_q.push_back({1'b1, b});
    end else if (o === lscp_pkg::OP_SOFTRST) begin
      exp_q.push_back({1'b0, o});
    end else if (o === lscp_pkg::OP_CONNECT && a < lscp_pkg::NUM_PORTS &&
                 b < lscp_pkg::NUM_PORTS) begin
      exp_q.push_back({1'b0, o});
      exp_q.push_back({1'b0, a});
      exp_q.push_back({1'b0, b});
    end
    put(h);
    put(o);
    put(a);
    put(b);
    up_valid = 1'b0;
    // Let an edge pass so the next record never re-raises valid in this step
    @(posedge clock);
    #1;
  endtask
  // Latch write, then a read cycle the level must survive
  task automatic wr(input logic [15:0] d);
    ext_wr = 1'b1;
    ext_wdata = d;
    @(posedge clock);
    #1 ext_wr = 1'b0;
    check({8'h00, sw_rst}, {8'h00, d[0]});
    ext_rd = 1'b1;
    @(posedge clock);
    #1 ext_rd = 1'b0;
    check({8'h00, sw_rst}, {8'h00, d[0]});
  endtask
  initial begin
    int k;
    logic [7:0] o;
    void'($urandom(32'hAC2C));
    repeat (12) @(posedge clock);
    #1 sys_rst = 1'b0;
    check({8'h00, sw_rst}, {8'h00, lscp_pkg::RST_ON});
    wr(16'h0000);
    repeat (6) @(posedge clock);
    #1 check({8'h00, sw_rst}, 9'h000);
    for (int i = 0; i < 8; i++) wr(16'($urandom()));
    wr(16'hFFFF);
    wr(16'hFFFE);
    rec(8'h00, 8'h00, 8'h1F, 8'h00);
    rec(8'h00, 8'h00, 8'h05, 8'h20);
    rec(8'h00, 8'h01, 8'h00, 8'h00);
    rec(8'h00, 8'h07, 8'h01, 8'h02);
    for (int i = 0; i < 40; i++) begin
      slow = (i >= 20);
      o = 8'($urandom_range(0, 2));
      k = (o == 8'h01) ? 31 : 35;
      rec(8'($urandom_range(0, 2)), o, 8'($urandom_range(0, k)),
          8'($urandom_range(0, k)));
    end
    for (k = 0; k < 1000 && exp_q.size() > 0; k++) @(posedge clock);
    if (exp_q.size() > 0) begin
      n_fail++;
    end
    repeat (4) @(posedge clock);
    close_out();
  end
endmodule
bind lscp_core lscp_core_chk u_chk (
  .clock     (clock),
  .sys_rst   (sys_rst),
  .up_valid  (up_valid),
  .up_data   (up_data),
  .up_ready  (up_ready),
  .sw_valid  (sw_valid),
  .sw_data   (sw_data),
  .sw_ready  (sw_ready),
  .dn_valid  (dn_valid),
  .dn_data   (dn_data),
  .dn_ready  (dn_ready),
  .ext_wr    (ext_wr),
  .ext_rd    (ext_rd),
  .ext_wdata (ext_wdata),
  .sw_rst    (sw_rst)
);
`default_nettype wire
